/* include/ocd_bus_if.sv */
// Parallel bus between host controller and panel command decoder.
// Assumes both ends share pclk; data lines resolved here from enables.
`timescale 1ns/10ps
interface ocd_bus_if;
    logic       cs;
    logic       cmd_data_select;
    logic       wr;
    logic       rd;
    logic       serial_mode;
    logic [7:0] host_dout;
    logic       host_oe;
    logic [7:0] dev_dout;
    logic       dev_oe;
    logic [7:0] data;

    // Wire level seen by the receiving end
    assign data = dev_oe ? dev_dout : (host_oe ? host_dout : 8'hFF);

    modport device (
        input  cs,
        input  cmd_data_select,
        input  wr,
        input  rd,
        input  serial_mode,
        input  data,
        output dev_dout,
        output dev_oe
    );
    modport host (
        output cs,
        output cmd_data_select,
        output wr,
        output rd,
        output serial_mode,
        output host_dout,
        output host_oe,
        input  data
    );
endinterface

/* include/ocd_defs.svh */
// Command codes, reset values and field positions of the panel command decoder.
// Assumes inclusion by bare name from include/.
`ifndef OCD_DEFS_SVH
`define OCD_DEFS_SVH
`define OCD_CMD_COL_LO    8'h00
`define OCD_CMD_COL_HI    8'h10
`define OCD_CMD_START     8'h40
`define OCD_CMD_CONTRAST  8'h81
`define OCD_CMD_MUX       8'hA8
`define OCD_CMD_DISP_OFF  8'hAE
`define OCD_CMD_DISP_ON   8'hAF
`define OCD_CMD_PAGE      8'hB0
`define OCD_CMD_SCAN      8'hC0
`define OCD_CMD_OFFSET    8'hD3
`define OCD_CMD_CLOCK     8'hD5
`define OCD_CMD_PERIOD    8'hD9
`define OCD_CMD_PADS      8'hDA
`define OCD_CMD_DESEL     8'hDB
`define OCD_CMD_RMW       8'hE0
`define OCD_CMD_END       8'hEE
`define OCD_CMD_NO_OP     8'hE3
`define OCD_RST_CLOCK     8'h50
`define OCD_RST_PERIOD    8'h22
`define OCD_RST_PADS      8'h12
`define OCD_RST_DESEL     8'h35
`define OCD_RST_CONTRAST  8'h80
`define OCD_RST_MUX       6'h3F
`define OCD_RST_OFFSET    6'h00
`define OCD_BUSY_CYCLES   4'h4
`define OCD_PADS_ALT_BIT  4
`define OCD_SCAN_BIT      3
`define OCD_STAT_BUSY_BIT 7
`define OCD_STAT_OFF_BIT  6
// APB controller register byte offsets
`define OCD_REG_CTRL      12'h000
`define OCD_REG_STATUS    12'h004
`define OCD_REG_RDATA     12'h008
`define OCD_CTRL_START    8
`define OCD_CTRL_SEL      9
`define OCD_CTRL_READ     10
`define OCD_CTRL_SERIAL   11
`endif

/* include/ocd_pkg.sv */
// Types of the host controller end of the panel command decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package ocd_pkg;
    typedef enum logic [1:0] {
        OCD_HS_IDLE,
        OCD_HS_SETUP,
        OCD_HS_STROBE,
        OCD_HS_WAIT
    } ocd_host_state_t;
endpackage

/* sim/ocd_monitor.sv */
// Checker on the panel bus between host controller and command decoder.
// Assumes HOLD_CYCLES of 6 in the host and one pclk domain.
`timescale 1ns/10ps
module ocd_monitor (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       cs,
    input wire logic       cmd_data_select,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic       serial_mode,
    input wire logic [7:0] host_dout,
    input wire logic       host_oe,
    input wire logic [7:0] dev_dout,
    input wire logic       dev_oe,
    input wire logic [7:0] data
);
    // ====================================================
    // Bus relations
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wr_width_a: assert property ($rose(wr) |-> wr[*7])
        else $error("write strobe shorter than seven cycles");
    wr_data_a: assert property (wr |-> host_oe && $stable(host_dout) && data == host_dout)
        else $error("write data not held on the bus");
    wr_sel_a: assert property (wr && $past(wr) |-> $stable(cmd_data_select))
        else $error("select moved during write strobe");
    rd_release_a: assert property (rd |-> !host_oe && !wr)
        else $error("host drives bus during read");
    oe_cause_a: assert property ($rose(dev_oe) |-> rd && cs)
        else $error("device drove bus without read");
    oe_drop_a: assert property ($fell(rd) |-> ##[0:5] !dev_oe)
        else $error("device kept driving after read");
    status_low_a: assert property (dev_oe && !cmd_data_select |-> dev_dout[2:0] == 3'h0)
        else $error("status low bits not zero");
    serial_read_a: assert property (serial_mode |-> !dev_oe)
        else $error("device drove bus in serial mode");
    no_clash_a: assert property (!(dev_oe && host_oe))
        else $error("both ends drive the bus");
endmodule

/* sim/testbench.sv */
// Self-checking bench: APB tasks drive the host, device outputs are compared.
// Assumes the host answers by pready; read data is taken at that edge.
`timescale 1ns/10ps
`include "ocd_defs.svh"
module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic        pready, pslverr;
    logic [3:0]  clock_divide, osc_trim, precharge_cycles, discharge_cycles;
    logic [7:0]  deselect_level, contrast, column;
    logic [5:0]  mux_ratio, display_offset, start_line;
    logic [2:0]  page;
    logic        pads_alternative, display_on, scan_reverse, rmw_mode, busy;
    int          err_total = 0, comparisons = 0;
    logic [7:0]  codes [7] = '{8'hD5, 8'hD9, 8'hDA, 8'hDB, 8'h81, 8'hA8, 8'hD3};
    logic [7:0]  resv [7] = '{8'h50, 8'h22, 8'h12, 8'h35, 8'h80, 8'h3F, 8'h00};
    logic [7:0]  newv [7] = '{8'hA7, 8'hF1, 8'h02, 8'h40, 8'hFF, 8'h15, 8'h3F};
    logic [7:0]  b;
    logic        e;

    always #2 pclk = ~pclk;

    ocd_bus_if u_ocd_bus_if ();
    ocd_host #(.HOLD_CYCLES(6)) u_ocd_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus(u_ocd_bus_if));
    ocd_device u_ocd_device (.pclk(pclk), .presetn(presetn), .bus(u_ocd_bus_if),
        .clock_divide(clock_divide), .osc_trim(osc_trim), .precharge_cycles(precharge_cycles),
        .discharge_cycles(discharge_cycles), .pads_alternative(pads_alternative),
        .deselect_level(deselect_level), .contrast(contrast), .display_on(display_on),
        .mux_ratio(mux_ratio), .scan_reverse(scan_reverse), .display_offset(display_offset),
        .start_line(start_line), .page(page), .column(column), .rmw_mode(rmw_mode), .busy(busy));
    ocd_monitor u_ocd_monitor (.pclk(pclk), .presetn(presetn), .cs(u_ocd_bus_if.cs),
        .cmd_data_select(u_ocd_bus_if.cmd_data_select), .wr(u_ocd_bus_if.wr),
        .rd(u_ocd_bus_if.rd), .serial_mode(u_ocd_bus_if.serial_mode),
        .host_dout(u_ocd_bus_if.host_dout), .host_oe(u_ocd_bus_if.host_oe),
        .dev_dout(u_ocd_bus_if.dev_dout), .dev_oe(u_ocd_bus_if.dev_oe),
        .data(u_ocd_bus_if.data));

    // ====================================================
    // Tasks
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wrt, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wrt;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Answer taken at the edge that samples pready high
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic issue(input logic rdo, input logic sel, input logic [7:0] v,
                         input logic ser = 1'b0);
        logic [31:0] q;
        logic        er;
        apb(1'b1, `OCD_REG_CTRL, {20'h00000, ser, rdo, sel, 1'b1, v}, q, er);
        do begin
            apb(1'b0, `OCD_REG_STATUS, 32'h00000000, q, er);
        end while (q[0] !== 1'b0);
        while (busy !== 1'b0) begin
            @(posedge pclk);
        end
    endtask

    task automatic rdbyte(input logic sel, output logic [7:0] v);
        logic [31:0] q;
        logic        er;
        issue(1'b1, sel, 8'h00);
        apb(1'b0, `OCD_REG_RDATA, 32'h00000000, q, er);
        v = q[7:0];
    endtask

    function automatic logic [7:0] obs(input logic [7:0] c);
        case (c)
            8'hD5:   obs = {osc_trim, clock_divide};
            8'hD9:   obs = {discharge_cycles, precharge_cycles};
            8'hDA:   obs = {3'h0, pads_alternative, 4'h2};
            8'hDB:   obs = deselect_level;
            8'h81:   obs = contrast;
            8'hA8:   obs = {2'h0, mux_ratio};
            default: obs = {2'h0, display_offset};
        endcase
    endfunction

    // ====================================================
    // Tests
    initial begin
        repeat (40000) @(posedge pclk);
        err_total++;
        give_verdict();
    end

    initial begin
        logic [31:0] q;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        for (int i = 0; i < 7; i++) chk(obs(codes[i]), resv[i]);
        chk({display_on, scan_reverse, start_line}, 8'h00);
        chk({page, 5'h00}, 8'h00);
        chk(column, 8'h00);
        chk({7'h00, busy}, 8'h01);
        $display("test reset values done");
        for (int i = 0; i < 7; i++) begin
            issue(1'b0, 1'b0, codes[i]);
            issue(1'b0, 1'b0, newv[i]);
            chk(obs(codes[i]), newv[i]);
        end
        issue(1'b0, 1'b0, 8'hD9);
        issue(1'b0, 1'b0, 8'h20);
        chk(obs(8'hD9), 8'hF1);
        issue(1'b0, 1'b0, 8'h81);
        issue(1'b0, 1'b0, 8'hAF);
        chk({contrast[7:1], display_on}, 8'hAE);
        $display("test two byte commands done");
        issue(1'b0, 1'b0, 8'hAF);
        rdbyte(1'b0, b);
        chk(b & 8'hC7, 8'h00);
        issue(1'b0, 1'b0, 8'hAE);
        rdbyte(1'b0, b);
        chk(b & 8'hC7, 8'h40);
        issue(1'b0, 1'b0, 8'hC8);
        issue(1'b0, 1'b0, 8'hB3);
        issue(1'b0, 1'b0, 8'h4A);
        issue(1'b0, 1'b0, 8'h05);
        issue(1'b0, 1'b0, 8'h12);
        chk({scan_reverse, 4'h0, page}, 8'h83);
        chk({2'h0, start_line}, 8'h0A);
        chk(column, 8'h25);
        issue(1'b0, 1'b0, 8'hE3);
        chk({contrast, column} == 16'hAF25, 8'h01);
        $display("test single byte commands done");
        issue(1'b0, 1'b0, 8'hE0);
        chk({7'h00, rmw_mode}, 8'h01);
        issue(1'b0, 1'b1, 8'h33);
        issue(1'b0, 1'b1, 8'h44);
        chk(column, 8'h27);
        issue(1'b0, 1'b0, 8'hEE);
        chk({rmw_mode, column[6:0]}, 8'h25);
        issue(1'b0, 1'b0, 8'hE0);
        rdbyte(1'b1, b);
        rdbyte(1'b1, b);
        chk(b, 8'h33);
        chk(column, 8'h25);
        issue(1'b0, 1'b0, 8'hEE);
        rdbyte(1'b1, b);
        chk(b, 8'h33);
        rdbyte(1'b1, b);
        chk(b, 8'h44);
        chk(column, 8'h27);
        issue(1'b1, 1'b1, 8'h00, 1'b1);
        apb(1'b0, `OCD_REG_RDATA, 32'h00000000, q, e);
        chk(q[7:0], 8'hFF);
        chk(column, 8'h27);
        $display("test display data done");
        apb(1'b0, 12'h00C, 32'h00000000, q, e);
        chk({7'h00, e}, 8'h01);
        $display("test unmapped address done");
        give_verdict();
    end
endmodule

/* src/ocd_device.sv */
// Panel command decoder: device end of the host bus.
// Assumes bus pins are asynchronous to pclk and are synchronised here.
// What this block does
// - D5H then byte: divide ratio nibble plus one
// - High clock nibble trims oscillator, five is nominal
// - Clock byte resets to 50H
// - D9H then byte: low nibble pre-charge cycles
// - High nibble discharge cycles, period resets 22H
// - DAH then 02H/12H, bit4 alternative, reset alternative
// - Row to pad ordering follows pad configuration; here only pads_alternative is output, with no row mapping
// - DBH then deselect byte, resets to 35H
// - E0H saves column, reads stop incrementing
// - EEH ends mode and restores column
// - Data write stores byte, column increments
// - Commands rejected while busy flag high
// - Status read: busy D7, off D6, low zeros
// - Data read returns RAM byte, column increments
// - Serial interface cannot read display RAM
// - Host may skip polling with enough spacing
// - Reset clears column, page and start line
// - 81H then contrast step, resets 80H
// - AEH off, AFH on, off after reset
// - A8H then six-bit mux, resets 3FH
// - Scan bit3 selects direction, reset forward
// - D3H then six-bit offset, resets 00H
// - After first byte next byte is data
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "ocd_defs.svh"
module ocd_device #(
    parameter int COLS  = 132,
    parameter int PAGES = 8
) (
    input  wire logic  pclk,
    input  wire logic  presetn,
    ocd_bus_if.device  bus,
    output logic [3:0] clock_divide,
    output logic [3:0] osc_trim,
    output logic [3:0] precharge_cycles,
    output logic [3:0] discharge_cycles,
    output logic       pads_alternative,
    output logic [7:0] deselect_level,
    output logic [7:0] contrast,
    output logic       display_on,
    output logic [5:0] mux_ratio,
    output logic       scan_reverse,
    output logic [5:0] display_offset,
    output logic [5:0] start_line,
    output logic [2:0] page,
    output logic [7:0] column,
    output logic       rmw_mode,
    output logic       busy
);
    // ============================================================
    // Pin synchronisers
    logic [1:0] wr_s, rd_s, sel_s, ser_s;
    logic [7:0] d_s1, d_s2;
    logic       wr_q, rd_q;
    logic       next_wr_q, next_rd_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_s  <= 2'h0;
            rd_s  <= 2'h0;
            sel_s <= 2'h0;
            ser_s <= 2'h0;
            d_s1  <= 8'h00;
            d_s2  <= 8'h00;
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
        end else begin
            wr_s  <= {wr_s[0], bus.wr & bus.cs};
            rd_s  <= {rd_s[0], bus.rd & bus.cs};
            sel_s <= {sel_s[0], bus.cmd_data_select};
            ser_s <= {ser_s[0], bus.serial_mode};
            d_s1  <= bus.data;
            d_s2  <= d_s1;
            wr_q  <= next_wr_q;
            rd_q  <= next_rd_q;
        end
    end
    logic wr_pulse, rd_pulse;
    always_comb begin
        next_wr_q = wr_s[1];
        next_rd_q = rd_s[1];
        wr_pulse  = wr_s[1] & ~wr_q;
        rd_pulse  = rd_s[1] & ~rd_q;
    end

    // ============================================================
    // Display RAM
    logic [7:0] ram [PAGES*COLS];
    logic [7:0] col_limit;
    assign col_limit = 8'(COLS - 1);
    logic [10:0] ram_idx;
    assign ram_idx = 11'(int'(page) * COLS + int'(column));

    // ============================================================
    // Command decoder state
    logic [7:0] clk_byte, per_byte, pads_byte, pend_cmd, rmw_col, rdata;
    logic [7:0] next_clk_byte, next_per_byte, next_pads_byte, next_deselect;
    logic [7:0] next_contrast, next_pend_cmd, next_rmw_col, next_column, next_rdata;
    logic [5:0] next_mux, next_offset, next_start;
    logic [2:0] next_page;
    logic [3:0] busy_cnt, next_busy_cnt;
    logic       pend, next_pend, next_on, next_scan, next_rmw, oe, next_oe;
    logic       ram_we;

    always_comb begin
        next_clk_byte  = clk_byte;
        next_per_byte  = per_byte;
        next_pads_byte = pads_byte;
        next_deselect  = deselect_level;
        next_contrast  = contrast;
        next_mux       = mux_ratio;
        next_offset    = display_offset;
        next_start     = start_line;
        next_page      = page;
        next_column    = column;
        next_on        = display_on;
        next_scan      = scan_reverse;
        next_rmw       = rmw_mode;
        next_rmw_col   = rmw_col;
        next_pend      = pend;
        next_pend_cmd  = pend_cmd;
        next_rdata     = rdata;
        next_oe        = rd_s[1];
        next_busy_cnt  = (busy_cnt != 4'h0) ? busy_cnt - 4'h1 : 4'h0;
        ram_we         = 1'b0;
        if (wr_pulse && sel_s[1]) begin
            ram_we = 1'b1;
            if (column != col_limit) next_column = column + 8'h01;
        end else if (wr_pulse && busy_cnt == 4'h0) begin
            next_busy_cnt = `OCD_BUSY_CYCLES;
            if (pend) begin
                next_pend = 1'b0;
                if (pend_cmd == `OCD_CMD_CLOCK) next_clk_byte = d_s2;
                else if (pend_cmd == `OCD_CMD_PERIOD) begin
                    if (d_s2[3:0] != 4'h0 && d_s2[7:4] != 4'h0) next_per_byte = d_s2;
                end else if (pend_cmd == `OCD_CMD_PADS) next_pads_byte = d_s2;
                else if (pend_cmd == `OCD_CMD_DESEL) next_deselect = d_s2;
                else if (pend_cmd == `OCD_CMD_CONTRAST) next_contrast = d_s2;
                else if (pend_cmd == `OCD_CMD_MUX) next_mux = d_s2[5:0];
                else if (pend_cmd == `OCD_CMD_OFFSET) next_offset = d_s2[5:0];
            end else if (d_s2 == `OCD_CMD_CLOCK || d_s2 == `OCD_CMD_PERIOD ||
                         d_s2 == `OCD_CMD_PADS || d_s2 == `OCD_CMD_DESEL ||
                         d_s2 == `OCD_CMD_CONTRAST || d_s2 == `OCD_CMD_MUX ||
                         d_s2 == `OCD_CMD_OFFSET) begin
                next_pend     = 1'b1;
                next_pend_cmd = d_s2;
            end else if ({d_s2[7:4], 4'h0} == `OCD_CMD_COL_LO) begin
                next_column = {column[7:4], d_s2[3:0]};
            end else if ({d_s2[7:4], 4'h0} == `OCD_CMD_COL_HI) begin
                next_column = {d_s2[3:0], column[3:0]};
            end else if ({d_s2[7:6], 6'h00} == `OCD_CMD_START) begin
                next_start = d_s2[5:0];
            end else if (d_s2 == `OCD_CMD_DISP_OFF || d_s2 == `OCD_CMD_DISP_ON) begin
                next_on = d_s2[0];
            end else if ({d_s2[7:3], 3'h0} == `OCD_CMD_PAGE) begin
                next_page = d_s2[2:0];
            end else if ({d_s2[7:4], 4'h0} == `OCD_CMD_SCAN) begin
                next_scan = d_s2[`OCD_SCAN_BIT];
            end else if (d_s2 == `OCD_CMD_RMW) begin
                next_rmw     = 1'b1;
                next_rmw_col = column;
            end else if (d_s2 == `OCD_CMD_END) begin
                next_rmw = 1'b0;
                if (rmw_mode) next_column = rmw_col;
            end
        end
        if (rd_pulse) begin
            if (!sel_s[1]) begin
                next_rdata = 8'h00;
                next_rdata[`OCD_STAT_BUSY_BIT] = busy;
                next_rdata[`OCD_STAT_OFF_BIT]  = ~display_on;
            end else if (!ser_s[1]) begin
                next_rdata = ram[ram_idx];
                if (!rmw_mode && column != col_limit)
                    next_column = column + 8'h01;
            end
        end
        if (ser_s[1] && sel_s[1]) next_oe = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_byte       <= `OCD_RST_CLOCK;
            per_byte       <= `OCD_RST_PERIOD;
            pads_byte      <= `OCD_RST_PADS;
            deselect_level <= `OCD_RST_DESEL;
            contrast       <= `OCD_RST_CONTRAST;
            mux_ratio      <= `OCD_RST_MUX;
            display_offset <= `OCD_RST_OFFSET;
            start_line     <= 6'h00;
            page           <= 3'h0;
            column         <= 8'h00;
            display_on     <= 1'b0;
            scan_reverse   <= 1'b0;
            rmw_mode       <= 1'b0;
            rmw_col        <= 8'h00;
            pend           <= 1'b0;
            pend_cmd       <= 8'h00;
            rdata          <= 8'h00;
            oe             <= 1'b0;
            busy_cnt       <= `OCD_BUSY_CYCLES;
        end else begin
            clk_byte       <= next_clk_byte;
            per_byte       <= next_per_byte;
            pads_byte      <= next_pads_byte;
            deselect_level <= next_deselect;
            contrast       <= next_contrast;
            mux_ratio      <= next_mux;
            display_offset <= next_offset;
            start_line     <= next_start;
            page           <= next_page;
            column         <= next_column;
            display_on     <= next_on;
            scan_reverse   <= next_scan;
            rmw_mode       <= next_rmw;
            rmw_col        <= next_rmw_col;
            pend           <= next_pend;
            pend_cmd       <= next_pend_cmd;
            rdata          <= next_rdata;
            oe             <= next_oe;
            busy_cnt       <= next_busy_cnt;
        end
    end

    // RAM has no reset; written only by data writes
    always_ff @(posedge pclk) begin
        if (ram_we) ram[ram_idx] <= d_s2;
    end

    // Decoded fields; pad ordering is given out only as pads_alternative
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_divide     <= 4'h0;
            osc_trim         <= 4'h5;
            precharge_cycles <= 4'h2;
            discharge_cycles <= 4'h2;
            pads_alternative <= 1'b1;
            busy             <= 1'b1;
        end else begin
            clock_divide     <= clk_byte[3:0];
            osc_trim         <= clk_byte[7:4];
            precharge_cycles <= per_byte[3:0];
            discharge_cycles <= per_byte[7:4];
            pads_alternative <= pads_byte[`OCD_PADS_ALT_BIT];
            busy             <= next_busy_cnt != 4'h0;
        end
    end
    assign bus.dev_dout = rdata;
    assign bus.dev_oe   = oe;
endmodule

/* src/ocd_host.sv */
// Host controller: APB slave registers driving the panel bus.
// Assumes APB master on pclk; device end samples with synchronisers.
`timescale 1ns/10ps
`include "ocd_defs.svh"
module ocd_host #(
    parameter int HOLD_CYCLES = 6
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    ocd_bus_if.host          bus
);
    // ============================================================
    // Data pin synchroniser
    logic [7:0] d1, d2;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            d1 <= 8'h00;
            d2 <= 8'h00;
        end else begin
            d1 <= bus.data;
            d2 <= d1;
        end
    end

    // ============================================================
    // Bus cycle sequencer; host honours spacing, busy poll optional
    ocd_pkg::ocd_host_state_t st, next_st;
    logic [7:0] cnt, next_cnt, byte_q, next_byte, rd_byte, next_rd_byte;
    logic       sel_q, next_sel, is_rd, next_is_rd, ser_q, next_ser;
    logic       wr_o, rd_o, oe_o, next_wr, next_rd, next_oe;
    logic [31:0] next_prdata;
    logic        next_pslverr, next_pready, access;
    assign access = psel & penable;

    always_comb begin
        next_st      = st;
        next_cnt     = cnt;
        next_byte    = byte_q;
        next_sel     = sel_q;
        next_is_rd   = is_rd;
        next_ser     = ser_q;
        next_rd_byte = rd_byte;
        next_wr      = wr_o;
        next_rd      = rd_o;
        next_oe      = oe_o;
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        case (st)
            ocd_pkg::OCD_HS_IDLE: begin
                if (access && pwrite && paddr == `OCD_REG_CTRL && pwdata[`OCD_CTRL_START]) begin
                    next_byte  = pwdata[7:0];
                    next_sel   = pwdata[`OCD_CTRL_SEL];
                    next_is_rd = pwdata[`OCD_CTRL_READ];
                    next_ser   = pwdata[`OCD_CTRL_SERIAL];
                    next_oe    = ~pwdata[`OCD_CTRL_READ];
                    next_cnt   = 8'(HOLD_CYCLES);
                    next_st    = ocd_pkg::OCD_HS_SETUP;
                end
            end
            ocd_pkg::OCD_HS_SETUP: begin
                next_cnt = cnt - 8'h01;
                if (cnt == 8'h00) begin
                    next_wr  = ~is_rd;
                    next_rd  = is_rd;
                    next_cnt = 8'(HOLD_CYCLES);
                    next_st  = ocd_pkg::OCD_HS_STROBE;
                end
            end
            ocd_pkg::OCD_HS_STROBE: begin
                next_cnt = cnt - 8'h01;
                if (cnt == 8'h00) begin
                    next_rd_byte = d2;
                    next_wr      = 1'b0;
                    next_rd      = 1'b0;
                    next_cnt     = 8'(HOLD_CYCLES);
                    next_st      = ocd_pkg::OCD_HS_WAIT;
                end
            end
            default: begin
                next_cnt = cnt - 8'h01;
                if (cnt == 8'h00) begin
                    next_oe = 1'b0;
                    next_st = ocd_pkg::OCD_HS_IDLE;
                end
            end
        endcase
        // Answer prepared in the setup cycle so it stands at the access edge
        next_pready = psel & ~penable;
        if (psel && !penable) begin
            if (!pwrite && paddr == `OCD_REG_STATUS) begin
                next_prdata = {31'h0, st != ocd_pkg::OCD_HS_IDLE};
            end else if (!pwrite && paddr == `OCD_REG_RDATA) begin
                next_prdata = {24'h0, rd_byte};
            end else if (!pwrite && paddr == `OCD_REG_CTRL) begin
                next_prdata = {20'h0, ser_q, is_rd, sel_q, 1'b0, byte_q};
            end else if (paddr != `OCD_REG_CTRL) begin
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st      <= ocd_pkg::OCD_HS_IDLE;
            cnt     <= 8'h00;
            byte_q  <= 8'h00;
            sel_q   <= 1'b0;
            is_rd   <= 1'b0;
            rd_byte <= 8'h00;
            wr_o    <= 1'b0;
            rd_o    <= 1'b0;
            oe_o    <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
            pready  <= 1'b0;
            ser_q   <= 1'b0;
        end else begin
            st      <= next_st;
            cnt     <= next_cnt;
            byte_q  <= next_byte;
            sel_q   <= next_sel;
            is_rd   <= next_is_rd;
            rd_byte <= next_rd_byte;
            wr_o    <= next_wr;
            rd_o    <= next_rd;
            oe_o    <= next_oe;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
            pready  <= next_pready;
            ser_q   <= next_ser;
        end
    end
    assign bus.cs              = 1'b1;
    assign bus.serial_mode     = ser_q;
    assign bus.cmd_data_select = sel_q;
    assign bus.wr              = wr_o;
    assign bus.rd              = rd_o;
    assign bus.host_dout       = byte_q;
    assign bus.host_oe         = oe_o;
endmodule
